// ==== mpic_ctrl.sv ====
// Sync pin, general purpose pin, fault interrupt and privacy current logic
`timescale 1ns/100ps
`include "mpic_defines.svh"

// Functional notes
// - Privacy current from peak bit and duty
// - GPIO bit0 makes pin A logic I/O
// - Pin B inhibit by default, bit3 GPIO
// - Pin B GPIO via bits 5:4
// - Pin B interrupt when bit6, bits4:3=11
// - Config1 bit6 selects inhibit polarity
// - Asserted inhibit during flash forces torch
// - Released inhibit restores flash level
// - Config2 bit0 makes inhibit force shutdown
// - Leave shutdown on a flags read
// - Flags read while asserted gives torch
// - Shutdown is edge triggered, rearmed by read
// - Interrupt low on any enabled fault
// - Interrupt released after fault gone and read
// - Flags read clears sync event flags
// - Sync edge direction set by polarity bits
module mpic_ctrl
(
   input wire logic hclk, // System clock
   input wire logic hresetn, // Async reset, active low
   input wire logic hsel, // Slave select
   input wire logic [31:0] haddr, // Byte address
   input wire logic [1:0] htrans, // Transfer type
   input wire logic hwrite, // Write when high
   input wire logic [2:0] hsize, // Transfer size
   input wire logic hready, // Bus ready in
   input wire logic [31:0] hwdata, // Write data
   output logic [31:0] hrdata, // Read data
   output logic hreadyout, // Slave ready
   output logic hresp, // Always OKAY
   input wire logic sync_a_torch_pin_i, // Pin A input level
   output logic sync_a_torch_pin_o, // Pin A output level
   output logic sync_a_torch_pin_oe_n, // Pin A drive enable, low drives
   input wire logic sync_b_multi_pin_i, // Pin B input level
   output logic sync_b_multi_pin_o, // Pin B output level
   output logic sync_b_multi_pin_oe_n, // Pin B drive enable, low drives
   input wire logic flash_active, // Flash event in progress
   input wire mpic_pkg::mpic_fault_s faults, // Fault comparator levels
   output mpic_pkg::mpic_level_e source_level, // Forced current level
   output logic [17:0] source_a_current, // Privacy current a, uA
   output logic [17:0] source_b_current, // Privacy current b, uA
   output logic irq // Level interrupt
);
   //----------------------------------------
   // Registers
   //----------------------------------------
   logic [7:0] gpio_r;
   logic [7:0] cfg1_r;
   logic [7:0] cfg2_r;
   logic [7:0] vmon_r;
   logic [7:0] priv_r;
   logic [7:0] flags_r;
   logic [7:0] flags_nxt;
   logic [2:0] irq_stat_r;
   logic [2:0] irq_en_r;
   logic [1:0] ctrl_r;
   logic [1:0] sa_sync_r;
   logic [1:0] sb_sync_r;
   logic sa_last_r;
   logic sb_last_r;
   logic armed_r;
   logic int_low_r;
   mpic_pkg::mpic_level_e lvl_r;
   logic [11:0] aph_addr_r;
   logic aph_wr_r;
   logic aph_rd_r;
   logic [17:0] src_a_r;
   logic [17:0] src_b_r;
   logic [31:0] hrdata_r;

   //----------------------------------------
   // Bus decode
   //----------------------------------------
   // Address phase qualification
   wire take = hsel & hready & htrans[1];
   wire wr_gpio = aph_wr_r & (aph_addr_r == `MPIC_OFF_GPIO);
   wire wr_cfg1 = aph_wr_r & (aph_addr_r == `MPIC_OFF_CFG1);
   wire wr_cfg2 = aph_wr_r & (aph_addr_r == `MPIC_OFF_CFG2);
   wire wr_vmon = aph_wr_r & (aph_addr_r == `MPIC_OFF_VMON);
   wire wr_priv = aph_wr_r & (aph_addr_r == `MPIC_OFF_PRIV);
   wire wr_en = aph_wr_r & (aph_addr_r == `MPIC_OFF_IRQ_EN);
   wire wr_clr = aph_wr_r & (aph_addr_r == `MPIC_OFF_IRQ_CLR);
   wire wr_ctrl = aph_wr_r & (aph_addr_r == `MPIC_OFF_CTRL);
   wire rd_flags = aph_rd_r & (aph_addr_r == `MPIC_OFF_FLAGS);

   //----------------------------------------
   // Pin modes and synchronised inputs
   //----------------------------------------
   wire a_gpio = gpio_r[`MPIC_GP_A_MODE];
   wire b_gpio = gpio_r[`MPIC_GP_B_MODE];
   wire b_int = gpio_r[`MPIC_GP_B_INT] & gpio_r[`MPIC_GP_B_DIR] & b_gpio;
   wire sa_lvl = sa_sync_r[1];
   wire sb_lvl = sb_sync_r[1];
   wire sa_act = sa_lvl ~^ cfg1_r[`MPIC_CFG1_POL_A];
   wire sb_act = sb_lvl ~^ cfg1_r[`MPIC_CFG1_POL_B];
   wire sa_edge = sa_act & ~sa_last_r & ~a_gpio;
   wire sb_edge = sb_act & ~sb_last_r & ~b_gpio;
   wire shdn_en = cfg2_r[`MPIC_CFG2_SHDN];

   // Enabled fault conditions
   wire f_therm = faults.therm_low & cfg1_r[`MPIC_CFG1_THERM];
   wire f_vsup = faults.vsup_trip & vmon_r[`MPIC_VMON_SUP];
   wire f_vflash = faults.vflash_trip & vmon_r[`MPIC_VMON_FLASH];
   wire any_fault = f_therm | f_vsup | f_vflash;
   wire [2:0] events = {sb_edge, sa_edge, any_fault & ~int_low_r};

   // Two-flop synchronisers
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         sa_sync_r <= 2'h0;
         sb_sync_r <= 2'h0;
      end
      else
      begin
         sa_sync_r <= {sa_sync_r[0], sync_a_torch_pin_i};
         sb_sync_r <= {sb_sync_r[0], sync_b_multi_pin_i};
      end
   end

   // Previous active levels for edge detection
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         sa_last_r <= 1'b0;
         sb_last_r <= 1'b0;
      end
      else
      begin
         sa_last_r <= sa_act;
         sb_last_r <= sb_act;
      end
   end

   //----------------------------------------
   // Flags, set wins over read clear
   //----------------------------------------
   always_comb
   begin
      flags_nxt = rd_flags ? 8'h00 : flags_r;
      if (sa_edge)
         flags_nxt[`MPIC_FLG_SYNC_A] = 1'b1;
      if (sb_edge)
         flags_nxt[`MPIC_FLG_SYNC_B] = 1'b1;
      if (f_therm)
         flags_nxt[`MPIC_FLG_THERM] = 1'b1;
      if (f_vflash)
         flags_nxt[`MPIC_FLG_VFLASH] = 1'b1;
      if (f_vsup)
         flags_nxt[`MPIC_FLG_VSUP] = 1'b1;
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         flags_r <= 8'h00;
      else
         flags_r <= flags_nxt;
   end

   //----------------------------------------
   // Forced current level
   //----------------------------------------
   // Torch while asserted, edge shutdown held until read
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         lvl_r <= mpic_pkg::MPIC_NORMAL;
         armed_r <= 1'b1;
      end
      else
      begin
         case (lvl_r)
            mpic_pkg::MPIC_SHUTDOWN:
            begin
               if (rd_flags)
               begin
                  armed_r <= 1'b1;
                  lvl_r <= sb_act ? mpic_pkg::MPIC_TORCH : mpic_pkg::MPIC_NORMAL;
               end
            end
            default:
            begin
               if (rd_flags)
                  armed_r <= 1'b1;
               if (shdn_en & sb_edge & armed_r & flash_active)
               begin
                  lvl_r <= mpic_pkg::MPIC_SHUTDOWN;
                  armed_r <= 1'b0;
               end
               else if (flash_active & sb_act & ~b_gpio)
                  lvl_r <= mpic_pkg::MPIC_TORCH;
               else
                  lvl_r <= mpic_pkg::MPIC_NORMAL;
            end
         endcase
      end
   end

   //----------------------------------------
   // Fault interrupt pin latch
   //----------------------------------------
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         int_low_r <= 1'b0;
      else if (any_fault)
         int_low_r <= 1'b1;
      else if (rd_flags)
         int_low_r <= 1'b0;
   end

   //----------------------------------------
   // Privacy current, per source
   //----------------------------------------
   // Duty plus one steps of the chosen unit
   wire [15:0] step = priv_r[3] ? `MPIC_STEP_HI_UA : `MPIC_STEP_LO_UA;
   wire [17:0] priv_ua = 18'(({15'h0, priv_r[2:0]} + 18'h1) * step);
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         src_a_r <= 18'h0;
         src_b_r <= 18'h0;
      end
      else
      begin
         src_a_r <= priv_r[4] ? priv_ua : 18'h0;
         src_b_r <= priv_r[5] ? priv_ua : 18'h0;
      end
   end

   //----------------------------------------
   // Register writes and bus state
   //----------------------------------------
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         gpio_r <= `MPIC_RST_GPIO;
         cfg1_r <= `MPIC_RST_CFG1;
         cfg2_r <= `MPIC_RST_CFG2;
         vmon_r <= `MPIC_RST_VMON;
         priv_r <= `MPIC_RST_PRIV;
         irq_en_r <= 3'h0;
         ctrl_r <= 2'h0;
         aph_addr_r <= 12'h0;
         aph_wr_r <= 1'b0;
         aph_rd_r <= 1'b0;
      end
      else
      begin
         aph_addr_r <= haddr[11:0];
         aph_wr_r <= take & hwrite;
         aph_rd_r <= take & ~hwrite;
         if (wr_gpio)
            gpio_r <= hwdata[7:0];
         if (wr_cfg1)
            cfg1_r <= hwdata[7:0];
         if (wr_cfg2)
            cfg2_r <= hwdata[7:0];
         if (wr_vmon)
            vmon_r <= hwdata[7:0];
         if (wr_priv)
            priv_r <= hwdata[7:0];
         if (wr_en)
            irq_en_r <= hwdata[2:0];
         if (wr_ctrl)
            ctrl_r <= hwdata[1:0];
      end
   end

   // Sticky interrupt status, set wins over clear
   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         irq_stat_r <= 3'h0;
      else
         irq_stat_r <= (irq_stat_r & ~(wr_clr ? hwdata[2:0] : 3'h0)) | events;
   end

   // Read mux, GPIO input bits show pin levels
   wire [7:0] gpio_rd = {gpio_r[7], gpio_r[6],
                         (b_gpio & ~gpio_r[`MPIC_GP_B_DIR]) ? sb_lvl : gpio_r[5],
                         gpio_r[4:3],
                         (a_gpio & ~gpio_r[`MPIC_GP_A_DIR]) ? sa_lvl : gpio_r[2],
                         gpio_r[1:0]};
   always_comb
   begin
      case (aph_addr_r)
         `MPIC_OFF_GPIO: hrdata_r = {24'h0, gpio_rd};
         `MPIC_OFF_FLAGS: hrdata_r = {24'h0, flags_r};
         `MPIC_OFF_CFG1: hrdata_r = {24'h0, cfg1_r};
         `MPIC_OFF_CFG2: hrdata_r = {24'h0, cfg2_r};
         `MPIC_OFF_VMON: hrdata_r = {24'h0, vmon_r};
         `MPIC_OFF_PRIV: hrdata_r = {24'h0, priv_r};
         `MPIC_OFF_IRQ_STAT: hrdata_r = {29'h0, irq_stat_r};
         `MPIC_OFF_IRQ_EN: hrdata_r = {29'h0, irq_en_r};
         `MPIC_OFF_CTRL: hrdata_r = {28'h0, lvl_r, ctrl_r};
         default: hrdata_r = 32'h0;
      endcase
   end

   //----------------------------------------
   // Outputs
   //----------------------------------------
   assign hrdata = aph_rd_r ? hrdata_r : 32'h0;
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   // Pin A drives its value bit when set as output
   assign sync_a_torch_pin_o = gpio_r[`MPIC_GP_A_VAL];
   assign sync_a_torch_pin_oe_n = ~(a_gpio & gpio_r[`MPIC_GP_A_DIR]);
   // Pin B drives low for interrupt, else value bit
   assign sync_b_multi_pin_o = b_int ? ~int_low_r : gpio_r[`MPIC_GP_B_VAL];
   assign sync_b_multi_pin_oe_n = ~(b_gpio & gpio_r[`MPIC_GP_B_DIR]);
   assign source_level = lvl_r;
   assign source_a_current = src_a_r;
   assign source_b_current = src_b_r;
   assign irq = |(irq_stat_r & irq_en_r);
endmodule

// ==== mpic_defines.svh ====
// Offsets, field positions, reset values and current steps of the sync pin controller
`ifndef MPIC_DEFINES_SVH
`define MPIC_DEFINES_SVH
`define MPIC_OFF_GPIO 12'h020
`define MPIC_OFF_FLAGS 12'h0d0
`define MPIC_OFF_CFG1 12'h0e0
`define MPIC_OFF_CFG2 12'h0f0
`define MPIC_OFF_VMON 12'h080
`define MPIC_OFF_PRIV 12'h100
`define MPIC_OFF_IRQ_STAT 12'h104
`define MPIC_OFF_IRQ_EN 12'h108
`define MPIC_OFF_IRQ_CLR 12'h10c
`define MPIC_OFF_CTRL 12'h110
`define MPIC_RST_GPIO 8'h80
`define MPIC_RST_CFG1 8'h6b
`define MPIC_RST_CFG2 8'he0
`define MPIC_RST_VMON 8'hc0
`define MPIC_RST_PRIV 8'h00
`define MPIC_GP_A_MODE 0
`define MPIC_GP_A_DIR 1
`define MPIC_GP_A_VAL 2
`define MPIC_GP_B_MODE 3
`define MPIC_GP_B_DIR 4
`define MPIC_GP_B_VAL 5
`define MPIC_GP_B_INT 6
`define MPIC_CFG1_THERM 4
`define MPIC_CFG1_POL_A 5
`define MPIC_CFG1_POL_B 6
`define MPIC_CFG2_SHDN 0
`define MPIC_VMON_SUP 0
`define MPIC_VMON_FLASH 3
`define MPIC_FLG_SYNC_A 3
`define MPIC_FLG_SYNC_B 4
`define MPIC_FLG_THERM 5
`define MPIC_FLG_VFLASH 6
`define MPIC_FLG_VSUP 7
`define MPIC_STEP_LO_UA 16'd3125
`define MPIC_STEP_HI_UA 16'd25000
`endif

// ==== mpic_pkg.sv ====
// Types shared by the sync pin controller
package mpic_pkg;
   typedef enum logic [1:0] {MPIC_NORMAL, MPIC_TORCH, MPIC_SHUTDOWN} mpic_level_e;
   typedef struct packed
   {
      logic therm_low;
      logic vsup_trip;
      logic vflash_trip;
   } mpic_fault_s;
   typedef struct packed
   {
      logic out;
      logic oe_n;
   } mpic_pin_drv_s;
endpackage

// ==== mpic_ctrl_checker.sv ====
// Port assertions for the sync pin controller
`timescale 1ns/100ps
`include "mpic_defines.svh"
module mpic_ctrl_checker
(
   input wire logic hclk, // Clock
   input wire logic hresetn, // Reset, low
   input wire logic hsel, // Select
   input wire logic [31:0] haddr, // Address
   input wire logic [1:0] htrans, // Type
   input wire logic hwrite, // Write
   input wire logic hready, // Ready in
   input wire logic [31:0] hrdata, // Read data
   input wire logic hreadyout, // Ready out
   input wire logic hresp, // Response
   input wire logic sync_b_multi_pin_o, // Pin B out
   input wire logic sync_b_multi_pin_oe_n, // Pin B enable
   input wire logic flash_active, // Flash on
   input wire mpic_pkg::mpic_level_e source_level, // Level
   input wire logic [17:0] source_a_current, // Current a
   input wire logic [17:0] source_b_current // Current b
);
   // Address phase qualifiers
   wire logic take = hsel && hready && htrans[1];
   wire logic flag_rd = take && !hwrite && haddr[11:0] == `MPIC_OFF_FLAGS;
   wire logic gpio_wr = take && hwrite && haddr[11:0] == `MPIC_OFF_GPIO;
   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);
   // Level transitions
   sequence s_shdn_out;
      source_level == mpic_pkg::MPIC_SHUTDOWN ##1 source_level != mpic_pkg::MPIC_SHUTDOWN;
   endsequence
   sequence s_shdn_in;
      source_level != mpic_pkg::MPIC_SHUTDOWN ##1 source_level == mpic_pkg::MPIC_SHUTDOWN;
   endsequence
   sequence s_torch_in;
      source_level == mpic_pkg::MPIC_NORMAL ##1 source_level == mpic_pkg::MPIC_TORCH;
   endsequence
   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus answer not ready and okay");
   a_rdata_idle: assert property (!$past(take && !hwrite) |-> hrdata == 32'h0)
      else $error("read data outside a read data phase");
   a_cur_a_step: assert property (source_a_current % 18'hc35 == 18'h0)
      else $error("current a off the step grid");
   a_cur_b_step: assert property (source_b_current % 18'hc35 == 18'h0)
      else $error("current b off the step grid");
   a_shdn_exit: assert property (s_shdn_out |-> $past(flag_rd, 2))
      else $error("shutdown left without a flags read");
   a_shdn_enter: assert property (s_shdn_in |-> $past(flash_active))
      else $error("shutdown outside a flash");
   a_torch_flash: assert property (s_torch_in |-> $past(flash_active))
      else $error("torch forced outside a flash");
   a_int_release: assert property (($rose(sync_b_multi_pin_o) && !sync_b_multi_pin_oe_n
      && $past(!sync_b_multi_pin_oe_n)) |-> ($past(flag_rd, 2) || $past(gpio_wr, 2)))
      else $error("interrupt pin released without a flags read");
endmodule
bind mpic_ctrl mpic_ctrl_checker mpic_ctrl_checker_i (.hclk(hclk), .hresetn(hresetn),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready),
   .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
   .sync_b_multi_pin_o(sync_b_multi_pin_o), .sync_b_multi_pin_oe_n(sync_b_multi_pin_oe_n),
   .flash_active(flash_active), .source_level(source_level),
   .source_a_current(source_a_current), .source_b_current(source_b_current));

// ==== mpic_rf_model.sv ====
// Pin level model that drives both sync pins
`timescale 1ns/100ps
module mpic_rf_model
(
   input wire logic [1:0] lvl, // Levels to drive, b then a
   input wire logic [1:0] dev_o, // Device pin outputs
   input wire logic [1:0] dev_oe_n, // Device enables, low drives
   output logic [1:0] pin // Resolved pin levels
);
   // Yield to the device where it drives, avoiding contention
   assign pin[0] = !dev_oe_n[0] ? dev_o[0] : lvl[0];
   assign pin[1] = !dev_oe_n[1] ? dev_o[1] : lvl[1];
endmodule

// ==== tb_multifunction_pin_interrupt_ctrl.sv ====
// Self-checking bench for the sync pin controller
`timescale 1ns/100ps
`include "mpic_defines.svh"
module tb_multifunction_pin_interrupt_ctrl;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq, flash_active;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [1:0] htrans, lvl, pin, pin_o, pin_oe_n;
   logic [17:0] cur_a, cur_b;
   mpic_pkg::mpic_fault_s faults;
   mpic_pkg::mpic_level_e source_level;
   int errors, compares, n;
   mpic_ctrl mpic_ctrl_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout), .hwdata(hwdata),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sync_a_torch_pin_i(pin[0]),
      .sync_a_torch_pin_o(pin_o[0]), .sync_a_torch_pin_oe_n(pin_oe_n[0]),
      .sync_b_multi_pin_i(pin[1]), .sync_b_multi_pin_o(pin_o[1]),
      .sync_b_multi_pin_oe_n(pin_oe_n[1]), .flash_active(flash_active), .faults(faults),
      .source_level(source_level), .source_a_current(cur_a), .source_b_current(cur_b),
      .irq(irq));
   mpic_rf_model mpic_rf_model_i (.lvl(lvl), .dev_o(pin_o), .dev_oe_n(pin_oe_n), .pin(pin));
   // Clock
   initial
   begin
      hclk = 1'b0;
      forever #25 hclk = ~hclk;
   end
   // Privacy current in uA for a peak and duty code
   function automatic logic [31:0] cur_exp(input logic [3:0] c);
      return (c[2:0] + 32'h1) * (c[3] ? 32'h61a8 : 32'hc35);
   endfunction
   task chk(input string s, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e)
      begin
         errors++;
         $display("BAD %s exp %h got %h", s, e, g);
      end
   endtask
   task test_done;
      $display("errors %0d compares %0d", errors, compares);
      if (errors == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // Bounded wait for ready at the next edges
   task rdy;
      n = 0;
      @(posedge hclk);
      while (hreadyout !== 1'b1)
      begin
         n++;
         if (n > 99)
         begin
            errors++;
            test_done;
         end
         @(posedge hclk);
      end
   endtask
   // One single word transfer; read data lands in q
   task bus(input logic w, input logic [11:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= {20'h0, a};
      hwrite <= w;
      rdy;
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      rdy;
      q = hrdata;
   endtask
   // Set pin B level, let it pass the synchroniser, check the level
   task step(input logic b, input mpic_pkg::mpic_level_e e);
      lvl[1] <= b;
      repeat (5) @(posedge hclk);
      chk("level", {30'h0, e}, {30'h0, source_level});
   endtask
   // Main sequence
   initial
   begin
      hresetn = 1'b0;
      {hsel, hwrite, flash_active, htrans, lvl, haddr, hwdata} = '0;
      faults = '0;
      void'($urandom(40));
      repeat (3) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      bus(1'b0, `MPIC_OFF_GPIO, 32'h0);
      chk("gpio", {24'h0, `MPIC_RST_GPIO}, q);
      chk("b_oe", 32'h1, {31'h0, pin_oe_n[1]});
      bus(1'b0, 12'h1fc, 32'h0);
      chk("hole", 32'h0, q);
      // Every peak and duty code
      for (int c = 0; c < 16; c++)
      begin
         bus(1'b1, `MPIC_OFF_PRIV, 32'h30 + 32'(c));
         repeat (2) @(posedge hclk);
         chk("cur_a", cur_exp(4'(c)), {14'h0, cur_a});
         chk("cur_b", cur_exp(4'(c)), {14'h0, cur_b});
      end
      // Pin A and pin B as outputs, then as inputs at random levels
      bus(1'b1, `MPIC_OFF_GPIO, 32'h3f);
      @(posedge hclk);
      chk("a_drv", 32'h3, {28'h0, pin_oe_n, pin_o});
      for (int i = 0; i < 6; i++)
      begin
         bus(1'b1, `MPIC_OFF_GPIO, 32'h9);
         lvl <= 2'($urandom);
         repeat (4) @(posedge hclk);
         bus(1'b0, `MPIC_OFF_GPIO, 32'h0);
         chk("gp_in", {26'h0, lvl[1], 2'h1, lvl[0], 2'h1}, q & 32'h7f);
      end
      // Inhibit at both polarities during a flash
      bus(1'b1, `MPIC_OFF_GPIO, 32'h0);
      lvl[0] <= 1'b0;
      flash_active <= 1'b1;
      for (int p = 0; p < 2; p++)
      begin
         lvl[1] <= p[0];
         bus(1'b1, `MPIC_OFF_CFG1, p ? 32'h2b : 32'h6b);
         step(p[0], mpic_pkg::MPIC_NORMAL);
         step(!p[0], mpic_pkg::MPIC_TORCH);
         step(p[0], mpic_pkg::MPIC_NORMAL);
      end
      // Edge-triggered shutdown and its release
      lvl[1] <= 1'b0;
      bus(1'b1, `MPIC_OFF_CFG1, 32'h7b);
      bus(1'b1, `MPIC_OFF_CFG2, 32'he1);
      bus(1'b0, `MPIC_OFF_FLAGS, 32'h0);
      lvl[0] <= 1'b1;
      step(1'b1, mpic_pkg::MPIC_SHUTDOWN);
      bus(1'b1, `MPIC_OFF_CTRL, 32'h3);
      bus(1'b0, `MPIC_OFF_CTRL, 32'h0);
      chk("ctrl", 32'hb, q);
      bus(1'b0, `MPIC_OFF_FLAGS, 32'h0);
      chk("flg_b", 32'h1, {31'h0, q[4]});
      chk("flg_a", 32'h1, {31'h0, q[3]});
      step(1'b1, mpic_pkg::MPIC_TORCH);
      bus(1'b0, `MPIC_OFF_FLAGS, 32'h0);
      chk("flg_clr", 32'h0, {31'h0, q[4]});
      step(1'b0, mpic_pkg::MPIC_NORMAL);
      step(1'b1, mpic_pkg::MPIC_SHUTDOWN);
      step(1'b0, mpic_pkg::MPIC_SHUTDOWN);
      bus(1'b0, `MPIC_OFF_FLAGS, 32'h0);
      step(1'b0, mpic_pkg::MPIC_NORMAL);
      flash_active <= 1'b0;
      // Interrupt pin for each fault, held until a flags read
      bus(1'b1, `MPIC_OFF_VMON, 32'hc9);
      bus(1'b1, `MPIC_OFF_IRQ_EN, 32'h1);
      bus(1'b1, `MPIC_OFF_GPIO, 32'h78);
      for (int f = 0; f < 3; f++)
      begin
         @(posedge hclk);
         chk("int_idle", 32'h1, {30'h0, pin_oe_n[1], pin_o[1]});
         faults <= 3'(1 << f);
         repeat (4) @(posedge hclk);
         chk("int_low", 32'h0, {30'h0, pin_oe_n[1], pin_o[1]});
         faults <= 3'h0;
         repeat (4) @(posedge hclk);
         chk("int_held", 32'h0, {31'h0, pin_o[1]});
         bus(1'b0, `MPIC_OFF_FLAGS, 32'h0);
      end
      // Interrupt line raised, masked and cleared
      chk("irq", 32'h1, {31'h0, irq});
      bus(1'b1, `MPIC_OFF_IRQ_EN, 32'h0);
      @(posedge hclk);
      chk("irq_mask", 32'h0, {31'h0, irq});
      bus(1'b1, `MPIC_OFF_IRQ_EN, 32'h1);
      bus(1'b1, `MPIC_OFF_IRQ_CLR, 32'h7);
      @(posedge hclk);
      chk("irq_clr", 32'h0, {31'h0, irq});
      test_done;
   end
endmodule
